// [hpm_pkg.sv]
// Constants and types for the host port mode and pin mux block
package hpm_pkg;
  // Data and pointer widths
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PTR_W = 6;
  // Strap codes on the mode pins
  localparam logic [1:0] STRAP_NONMUX = 2'h0;
  localparam logic [1:0] STRAP_MUX = 2'h1;
  localparam logic [1:0] STRAP_SERIAL = 2'h2;
  localparam logic [1:0] STRAP_RSVD = 2'h3;
  // Interrupt pin signalling styles
  localparam logic [1:0] IRQ_ACT_HIGH = 2'h0;
  localparam logic [1:0] IRQ_ACT_LOW = 2'h1;
  localparam logic [1:0] IRQ_OPEN_DRAIN = 2'h2;
  // Bit of the shared bus that carries serial output
  localparam int unsigned SER_OUT_BIT = 0;
  // Reset values
  localparam logic [PTR_W-1:0] PTR_RST = 6'h00;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  // Host interface modes
  typedef enum logic [1:0] {HPM_NONMUX, HPM_MUX, HPM_SERIAL} hpm_mode_t;
endpackage

// [hpm_strb_if.sv]
// Strobe pin copies and their edge events
`timescale 1ns/1ns
`default_nettype none
interface hpm_strb_if;
  logic rd_n;
  logic wr_n;
  logic ale;
  logic rd_rise;
  logic wr_rise;
  logic ale_fall;
  modport det (input rd_n, input wr_n, input ale, output rd_rise, output wr_rise, output ale_fall);
  modport user (output rd_n, output wr_n, output ale, input rd_rise, input wr_rise, input ale_fall);
endinterface
`default_nettype wire

// [hpm_edge_det.sv]
// Edge detector for the host strobes
`timescale 1ns/1ns
`default_nettype none
module hpm_edge_det (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Strobes and events
  hpm_strb_if.det strb
);
  logic rd_n_q, rd_n_d;
  logic wr_n_q, wr_n_d;
  logic ale_q, ale_d;

  // Previous strobe levels; idle values avoid false edges after reset
  always_comb begin
    rd_n_d = strb.rd_n;
    wr_n_d = strb.wr_n;
    ale_d = strb.ale;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rd_n_q <= 1'b1;
      wr_n_q <= 1'b1;
      ale_q <= 1'b0;
    end else if (ce) begin
      rd_n_q <= rd_n_d;
      wr_n_q <= wr_n_d;
      ale_q <= ale_d;
    end
  end

  // Strobe end marks the access, data is stable there
  assign strb.rd_rise = strb.rd_n & ~rd_n_q;
  assign strb.wr_rise = strb.wr_n & ~wr_n_q;
  assign strb.ale_fall = ~strb.ale & ale_q;
endmodule
`default_nettype wire

// [hpm_host_port.sv]
// Host port: mode straps, shared pin mux, pointer and data registers
// What this block does
// - Mode pins select nonmux, mux or serial
// - Code 11 behaves as serial mode
// - DMA acknowledge low active, only when enabled
// - DMA request inactive unless DMA enabled
// - Interrupt pin style: high, low, open drain
// - Interrupt pin released while reset applied
// - Chip select and read strobe active low
// - Write pin: strobe in parallel, shift clock serial
// - Select pin: register select, latch, serial input
// - Bus: data, muxed bus, bit0 serial output
// - Nonmux mode uses select, strobes, 8-bit bus
// - Nonmux exposes only pointer, write, read registers
// - Standard and burst access both supported
// - Select low data, high write loads pointer
// - Read data reloads after pointer, read, write
// - Burst keeps pointer, refreshes after each read
// - Mux mode latches pointer while latch strobe high
`timescale 1ns/1ns
`default_nettype none
module hpm_host_port (
  // Clock, reset, enable
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic CE,
  // Mode straps
  input wire logic [1:0] MODE_PINS,
  // Host control pins
  input wire logic CS_N,
  input wire logic RD_N,
  input wire logic WR_PIN,
  input wire logic SEL_PIN,
  // Shared bus pins
  input wire logic [7:0] BUS_IN,
  output logic [7:0] BUS_OUT,
  output logic [7:0] BUS_OE,
  // DMA pins and engine side
  input wire logic DMA_ACK_N,
  input wire logic DMA_ENABLE,
  input wire logic DMA_PENDING,
  output logic DMA_REQUEST,
  output logic DMA_ACK_ACTIVE,
  // Interrupt pin and its control
  input wire logic IRQ_PENDING,
  input wire logic [1:0] IRQ_STYLE,
  output logic IRQ_OUT,
  output logic IRQ_OE,
  // Internal register file access
  output logic [5:0] REG_ADDR,
  output logic [7:0] REG_WDATA,
  output logic REG_WR,
  input wire logic [7:0] REG_RDATA,
  // Serial engine side
  output logic SER_SHIFT_CLK,
  output logic SER_IN,
  output logic SER_CS_N,
  input wire logic SER_OUT,
  // Status
  output logic [1:0] MODE_STATUS
);
  hpm_pkg::hpm_mode_t mode_q, mode_d;
  logic strap_q, strap_d;
  logic [5:0] ptr_q, ptr_d;
  logic [7:0] wdata_q, wdata_d;
  logic [7:0] rdata_q, rdata_d;
  logic reload_q, reload_d;
  logic reg_wr_q, reg_wr_d;
  logic [7:0] bus_out_q, bus_out_d;
  logic [7:0] bus_oe_q, bus_oe_d;
  logic irq_out_q, irq_out_d;
  logic irq_oe_q, irq_oe_d;
  logic dreq_q, dreq_d;
  logic dma_ack_n_q, dma_ack_n_d;
  logic sclk_q, sclk_d;
  logic sin_q, sin_d;
  logic scs_n_q, scs_n_d;
  logic nonmux, mux, serial, par, sel;
  logic ptr_wr_ev, data_wr_ev, data_rd_ev;

  hpm_strb_if strb ();

  // Strobe copies for the edge detector
  assign strb.rd_n = RD_N;
  assign strb.wr_n = WR_PIN;
  assign strb.ale = SEL_PIN;

  hpm_edge_det u_edge (
    .clk(CORE_CLK),
    .rst(RST),
    .ce(CE),
    .strb(strb)
  );

  // Strap decode
  function automatic hpm_pkg::hpm_mode_t mode_of(input logic [1:0] pins);
    case (pins)
      hpm_pkg::STRAP_NONMUX: mode_of = hpm_pkg::HPM_NONMUX;
      hpm_pkg::STRAP_MUX: mode_of = hpm_pkg::HPM_MUX;
      hpm_pkg::STRAP_SERIAL: mode_of = hpm_pkg::HPM_SERIAL;
      default: mode_of = hpm_pkg::HPM_SERIAL;
    endcase
  endfunction

  // Mode decode, and access events, the events all gated by chip select
  assign nonmux = (mode_q == hpm_pkg::HPM_NONMUX);
  assign mux = (mode_q == hpm_pkg::HPM_MUX);
  assign serial = (mode_q == hpm_pkg::HPM_SERIAL);
  assign par = strap_q && !serial;
  assign sel = par && !CS_N;
  assign ptr_wr_ev = sel && nonmux && SEL_PIN && strb.wr_rise;
  assign data_wr_ev = sel && !SEL_PIN && strb.wr_rise;
  assign data_rd_ev = sel && !SEL_PIN && strb.rd_rise;

  // Straps sampled once after reset; board keeps them fixed
  always_comb begin
    mode_d = mode_q;
    strap_d = 1'b1;
    if (!strap_q) begin
      mode_d = mode_of(MODE_PINS);
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      mode_q <= hpm_pkg::HPM_SERIAL;
      strap_q <= 1'b0;
    end else if (CE) begin
      mode_q <= mode_d;
      strap_q <= strap_d;
    end
  end

  // Pointer, write data and read data; other registers only via these
  always_comb begin
    ptr_d = ptr_q;
    wdata_d = wdata_q;
    rdata_d = rdata_q;
    reload_d = reg_wr_q;
    reg_wr_d = 1'b0;
    if (reload_q) begin
      rdata_d = REG_RDATA;
    end
    if (sel && mux && SEL_PIN) begin
      ptr_d = BUS_IN[5:0];
    end
    if (sel && mux && strb.ale_fall) begin
      reload_d = 1'b1;
    end
    if (ptr_wr_ev) begin
      ptr_d = BUS_IN[5:0];
      reload_d = 1'b1;
    end
    if (data_wr_ev) begin
      wdata_d = BUS_IN;
      reg_wr_d = 1'b1;
    end
    if (data_rd_ev) begin
      reload_d = 1'b1;
    end
  end

  // Reload after a write waits for the write to land in the file
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      ptr_q <= hpm_pkg::PTR_RST;
      wdata_q <= hpm_pkg::DATA_RST;
      rdata_q <= hpm_pkg::DATA_RST;
      reload_q <= 1'b0;
      reg_wr_q <= 1'b0;
    end else if (CE) begin
      ptr_q <= ptr_d;
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
      reload_q <= reload_d;
      reg_wr_q <= reg_wr_d;
    end
  end

  // Pin drivers: bus, DMA, interrupt, serial lines
  always_comb begin
    bus_out_d = rdata_q;
    bus_oe_d = 8'h00;
    dreq_d = DMA_ENABLE && DMA_PENDING && par;
    dma_ack_n_d = DMA_ENABLE && !DMA_ACK_N && CS_N && par;
    sclk_d = serial ? WR_PIN : 1'b0;
    sin_d = serial ? SEL_PIN : 1'b0;
    scs_n_d = serial ? CS_N : 1'b1;
    irq_out_d = 1'b0;
    irq_oe_d = 1'b1;
    if (sel && !RD_N) begin
      bus_oe_d = 8'hFF;
    end
    if (serial && !CS_N) begin
      bus_out_d[hpm_pkg::SER_OUT_BIT] = SER_OUT;
      bus_oe_d[hpm_pkg::SER_OUT_BIT] = 1'b1;
    end
    case (IRQ_STYLE)
      hpm_pkg::IRQ_ACT_HIGH: irq_out_d = IRQ_PENDING;
      hpm_pkg::IRQ_ACT_LOW: irq_out_d = !IRQ_PENDING;
      default: irq_oe_d = IRQ_PENDING; // Open drain: pull low only
    endcase
  end

  // Interrupt pin floats through reset
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      bus_out_q <= 8'h00;
      bus_oe_q <= 8'h00;
      dreq_q <= 1'b0;
      dma_ack_n_q <= 1'b0;
      sclk_q <= 1'b0;
      sin_q <= 1'b0;
      scs_n_q <= 1'b1;
      irq_out_q <= 1'b0;
      irq_oe_q <= 1'b0;
    end else if (CE) begin
      bus_out_q <= bus_out_d;
      bus_oe_q <= bus_oe_d;
      dreq_q <= dreq_d;
      dma_ack_n_q <= dma_ack_n_d;
      sclk_q <= sclk_d;
      sin_q <= sin_d;
      scs_n_q <= scs_n_d;
      irq_out_q <= irq_out_d;
      irq_oe_q <= irq_oe_d;
    end
  end

  // Outputs straight from flops
  assign BUS_OUT = bus_out_q;
  assign BUS_OE = bus_oe_q;
  assign DMA_REQUEST = dreq_q;
  assign DMA_ACK_ACTIVE = dma_ack_n_q;
  assign IRQ_OUT = irq_out_q;
  assign IRQ_OE = irq_oe_q;
  assign REG_ADDR = ptr_q;
  assign REG_WDATA = wdata_q;
  assign REG_WR = reg_wr_q;
  assign SER_SHIFT_CLK = sclk_q;
  assign SER_IN = sin_q;
  assign SER_CS_N = scs_n_q;
  assign MODE_STATUS = mode_q;

  // Checks
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  property p_strap_map;
    (!strap_q && CE) |=> (mode_q == mode_of($past(MODE_PINS))) && strap_q;
  endproperty
  a_strap_map: assert property (p_strap_map) else $error("mode not taken from straps");

  property p_rsvd_serial;
    (!strap_q && CE && MODE_PINS == hpm_pkg::STRAP_RSVD) |=> serial ##1 serial;
  endproperty
  a_rsvd_serial: assert property (p_rsvd_serial) else $error("reserved strap not serial");

  property p_dma_ack_n_quiet;
    (CE && !DMA_ENABLE) |=> !DMA_ACK_ACTIVE;
  endproperty
  a_dma_ack_n_quiet: assert property (p_dma_ack_n_quiet) else $error("ack active without DMA");

  property p_dreq_quiet;
    (CE && (!DMA_ENABLE || serial)) |=> !DMA_REQUEST;
  endproperty
  a_dreq_quiet: assert property (p_dreq_quiet) else $error("request without DMA");

  property p_irq_low;
    (CE && IRQ_STYLE == hpm_pkg::IRQ_ACT_LOW && IRQ_PENDING) |=> IRQ_OE && !IRQ_OUT;
  endproperty
  a_irq_low: assert property (p_irq_low) else $error("active low irq wrong");

  property p_irq_reset;
    @(posedge CORE_CLK) disable iff (1'b0) RST |=> !IRQ_OE;
  endproperty
  a_irq_reset: assert property (p_irq_reset) else $error("irq driven in reset");

  property p_serial_map;
    (CE && serial) |=> SER_SHIFT_CLK == $past(WR_PIN) && SER_IN == $past(SEL_PIN);
  endproperty
  a_serial_map: assert property (p_serial_map) else $error("serial pin map wrong");

  property p_ptr_write;
    (CE && ptr_wr_ev) |=> REG_ADDR == $past(BUS_IN[5:0]);
  endproperty
  a_ptr_write: assert property (p_ptr_write) else $error("pointer not loaded");

  property p_reload;
    (CE && ptr_wr_ev) ##1 CE |=> rdata_q == $past(REG_RDATA);
  endproperty
  a_reload: assert property (p_reload) else $error("read data not reloaded");

  property p_burst_ptr;
    (CE && nonmux && data_rd_ev) |=> $stable(REG_ADDR);
  endproperty
  a_burst_ptr: assert property (p_burst_ptr) else $error("pointer moved on read");

  property p_ale_latch;
    (CE && sel && mux && SEL_PIN) |=> REG_ADDR == $past(BUS_IN[5:0]);
  endproperty
  a_ale_latch: assert property (p_ale_latch) else $error("address not latched");

  property p_bus_release;
    (CE && !serial && (CS_N || RD_N)) |=> BUS_OE == 8'h00;
  endproperty
  a_bus_release: assert property (p_bus_release) else $error("bus driven outside read");

  c_ptr_write: cover property (CE && ptr_wr_ev);
  c_data_write: cover property (CE && data_wr_ev ##1 CE ##1 reload_q);
  c_burst_reads: cover property (CE && data_rd_ev ##[1:20] CE && data_rd_ev);
  c_serial_out: cover property (serial && BUS_OE[0]);
endmodule
`default_nettype wire

// [hpm_cpu_model.sv]
// Behavioural CPU on the shared host pins
`timescale 1ns/1ns
`default_nettype none
module hpm_cpu_model (
  // Clock
  input wire logic clk,
  // Resolved bus level
  input wire logic [7:0] bus_in,
  // Host control pins
  output logic cs_n,
  output logic rd_n,
  output logic wr_n,
  output logic sel,
  output logic [7:0] bus
);
  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    sel = 1'b0;
    bus = 8'h00;
  end
  // Set all pins after an edge, hold n edges
  task automatic pins(input logic c, r, w, s, input logic [7:0] b, input int n);
    cs_n <= c;
    rd_n <= r;
    wr_n <= w;
    sel <= s;
    bus <= b;
    repeat (n) @(posedge clk);
  endtask
  // One strobe; data stands through the strobe's end, where the port takes it
  task automatic access(input logic rd, s, input logic [7:0] d, output logic [7:0] q);
    pins(1'b0, ~rd, rd, s, d, 3);
    q = bus_in;
    pins(1'b0, 1'b1, 1'b1, s, d, 1);
    pins(1'b1, 1'b1, 1'b1, 1'b0, ~d, 4);
  endtask
  // Address phase of the multiplexed bus
  task automatic latch(input logic [7:0] a);
    pins(1'b0, 1'b1, 1'b1, 1'b1, a, 2);
    pins(1'b0, 1'b1, 1'b1, 1'b0, ~a, 1);
  endtask
endmodule
`default_nettype wire

// [hpm_host_port_tb.sv]
// Self-checking bench for the host port
`timescale 1ns/1ns
`default_nettype none
module hpm_host_port_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] mode = 2'h0;
  logic dma_ack_n = 1'b1;
  logic dma_en = 1'b0;
  logic dma_pend = 1'b0;
  logic irq_pend = 1'b1;
  logic [1:0] irq_style = 2'h0;
  logic ser_out = 1'b1;
  logic ce = 1'b1;
  logic cs_n, rd_n, wr_n, sel;
  logic [7:0] cpu_bus, bus_in, bus_out, bus_oe, reg_wdata, reg_rdata, q;
  logic [5:0] reg_addr;
  logic [1:0] mode_status;
  logic reg_wr, dma_req, dma_ack_act, irq_out, irq_oe, ser_clk, ser_in, ser_cs_n;
  logic [7:0] mem [64];
  logic [4:0] rows [8];
  int n_fail = 0;
  int checks_done = 0;
  // Clock at 125 MHz
  always #4 clk = ~clk;
  // Each bit of the bus resolved from both drivers
  assign bus_in = (bus_oe & bus_out) | (~bus_oe & cpu_bus);
  // Internal register file
  assign reg_rdata = mem[reg_addr];
  always @(posedge clk) if (reg_wr === 1'b1) mem[reg_addr] <= reg_wdata;
  hpm_cpu_model u_cpu (.clk(clk), .bus_in(bus_in), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .sel(sel), .bus(cpu_bus));
  hpm_host_port u_dut (.CORE_CLK(clk), .RST(rst), .CE(ce), .MODE_PINS(mode), .CS_N(cs_n), .RD_N(rd_n),
    .WR_PIN(wr_n), .SEL_PIN(sel), .BUS_IN(bus_in), .BUS_OUT(bus_out), .BUS_OE(bus_oe), .DMA_ACK_N(dma_ack_n),
    .DMA_ENABLE(dma_en), .DMA_PENDING(dma_pend), .DMA_REQUEST(dma_req), .DMA_ACK_ACTIVE(dma_ack_act),
    .IRQ_PENDING(irq_pend), .IRQ_STYLE(irq_style), .IRQ_OUT(irq_out), .IRQ_OE(irq_oe), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RDATA(reg_rdata), .SER_SHIFT_CLK(ser_clk), .SER_IN(ser_in),
    .SER_CS_N(ser_cs_n), .SER_OUT(ser_out), .MODE_STATUS(mode_status));
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic results();
    if (n_fail == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Reset with new straps; interrupt pin must float meanwhile
  task automatic rst_mode(input logic [1:0] m);
    mode <= m;
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    chk("irq_oe_rst", 8'h00, {7'h0, irq_oe});
    chk("bus_oe_rst", 8'h00, bus_oe);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  // Watchdog, far beyond the roughly 150 cycles needed
  initial begin
    #200000;
    n_fail++;
    results();
  end
  initial begin
    for (int i = 0; i < 64; i++) mem[i] = 8'(i) ^ 8'hA5;
    // Style, pending, expected out, expected enable
    rows = '{5'b00_1_1_1, 5'b00_0_0_1, 5'b01_1_0_1, 5'b01_0_1_1,
      5'b10_1_0_1, 5'b10_0_0_0, 5'b11_1_0_1, 5'b11_0_0_0};
    for (int m = 0; m < 4; m++) begin
      rst_mode(2'(m));
      chk("mode", (m == 3) ? 8'h02 : 8'(m), {6'h0, mode_status});
    end
    rst_mode(2'h0);
    // Interrupt styles; open drain drives only low
    foreach (rows[i]) begin
      irq_style <= rows[i][4:3];
      irq_pend <= rows[i][2];
      repeat (2) @(posedge clk);
      chk("irq_oe", {7'h0, rows[i][0]}, {7'h0, irq_oe});
      if (rows[i][0]) chk("irq_out", {7'h0, rows[i][1]}, {7'h0, irq_out});
    end
    // Request only with DMA on; acknowledge seen with chip select high
    dma_pend <= 1'b1;
    dma_ack_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk("drq_off", 8'h00, {6'h0, dma_req, dma_ack_act});
    dma_en <= 1'b1;
    repeat (2) @(posedge clk);
    chk("drq_on", 8'h03, {6'h0, dma_req, dma_ack_act});
    dma_en <= 1'b0;
    dma_ack_n <= 1'b1;
    // Standard then burst accesses
    u_cpu.access(1'b0, 1'b1, 8'hD5, q);
    chk("ptr", 8'h15, {2'h0, reg_addr});
    u_cpu.access(1'b1, 1'b0, 8'h00, q);
    chk("rd", 8'hB0, q);
    chk("bus_oe_idle", 8'h00, bus_oe);
    u_cpu.access(1'b0, 1'b0, 8'h3C, q);
    chk("file", 8'h3C, mem[21]);
    // New file value shows only after the next read's refresh
    mem[21] <= 8'h5A;
    u_cpu.access(1'b1, 1'b0, 8'h00, q);
    chk("rd_wr", 8'h3C, q);
    u_cpu.access(1'b1, 1'b0, 8'h00, q);
    chk("burst", 8'h5A, q);
    chk("ptr_keep", 8'h15, {2'h0, reg_addr});
    // Write with chip select high is ignored
    u_cpu.pins(1'b1, 1'b1, 1'b0, 1'b0, 8'h99, 3);
    u_cpu.pins(1'b1, 1'b1, 1'b1, 1'b0, 8'h66, 4);
    chk("cs_ign", 8'h5A, mem[21]);
    // Clock enable low freezes the port, so a whole pointer write is lost
    ce <= 1'b0;
    u_cpu.access(1'b0, 1'b1, 8'h3F, q);
    ce <= 1'b1;
    chk("ce_hold", 8'h15, {2'h0, reg_addr});
    // Multiplexed address phase then read
    rst_mode(2'h1);
    u_cpu.latch(8'h2A);
    chk("mux_ptr", 8'h2A, {2'h0, reg_addr});
    u_cpu.access(1'b1, 1'b0, 8'h00, q);
    chk("mux_rd", 8'h8F, q);
    // Serial pins and output on bus bit zero
    rst_mode(2'h2);
    u_cpu.pins(1'b0, 1'b1, 1'b1, 1'b0, 8'h00, 3);
    chk("ser", 8'h05, {4'h0, ser_cs_n, ser_clk, ser_in, bus_oe[0]});
    chk("ser_out", 8'h01, {7'h0, bus_out[0]});
    // Opposite levels catch swapped clock and data pins
    u_cpu.pins(1'b0, 1'b1, 1'b0, 1'b1, 8'h00, 2);
    chk("ser_swap", 8'h03, {4'h0, ser_cs_n, ser_clk, ser_in, bus_oe[0]});
    results();
  end
endmodule
`default_nettype wire
